/* File: pkg/scaler_defines.vh */
`ifndef SCALER_DEFINES_VH
`define SCALER_DEFINES_VH
// register offsets (byte addresses)
`define OFS_CTRL          12'h000
`define OFS_ID_IRQ        12'h004
`define OFS_CNT_DISABLE   12'h00C
`define OFS_KEY_CLEAR     12'h030
`define OFS_KEY_SHADOW    12'h034
`define OFS_KEY_CNT_ON    12'h038
`define OFS_KEY_CNT_OFF   12'h03C
`define OFS_OVF_1_8       12'h380
`define OFS_OVF_9_16      12'h3A0
`define OFS_OVF_17_24     12'h3C0
`define OFS_OVF_25_32     12'h3E0
// readout windows, upper address bits [11:7]
`define WIN_SHADOW        5'h04
`define WIN_READ_CNT      5'h05
`define WIN_READ_CLR      5'h06
// control register set / clear bit positions
`define CTL_SET_TEST_IRQ  1
`define CTL_CLR_TEST_IRQ  9
`define CTL_SET_BCAST     6
`define CTL_CLR_BCAST     14
`define CTL_SET_BCAST_HS  7
`define CTL_CLR_BCAST_HS  15
`define CTL_SET_IRQ_SRC   20
`define CTL_CLR_IRQ_SRC   28
// status read positions in the control register
`define STS_IRQ_PENDING   16
`define STS_IRQ_COND      24
// id / irq register fields
`define IDR_IRQ_ENABLE    11
`define IDR_LEVEL_LSB     8
`define IDR_VERSION_LSB   12
`define IDR_MODULE_LSB    16
// overflow flags sit in the top byte
`define OVF_LSB           24
// reset values
`define RST_ID_IRQ        12'h000
`define RST_DISABLE_MASK  32'h00000000
`endif

/* File: design/shadow_store.v */
// shadow register file: whole-array load, one registered read port
module shadow_store #(
  parameter WIDTH = 32,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk, // system clock
  input wire load_all, // copy every word at once
  input wire [WIDTH*DEPTH-1:0] data_all, // packed words, word 0 lowest
  input wire [AW-1:0] rd_addr, // word to read
  output reg [WIDTH-1:0] rd_data_q // registered read data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // stored words
  integer i;

  // parallel load of all words
  always @(posedge clk) begin
    if (load_all) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= data_all[i*WIDTH +: WIDTH];
      end
    end
  end

  // registered read, returns contents before a same-edge load
  always @(posedge clk) begin
    rd_data_q <= mem_q[rd_addr];
  end
endmodule

/* File: design/scaler_readout_control.v */
`include "scaler_defines.vh"
module scaler_readout_control #(
  parameter CHANNELS = 32,
  parameter CW = 32,
  parameter [15:0] MODULE_ID = 16'h1234, // arbitrary value
  parameter [3:0] VERSION_ID = 4'h1 // arbitrary value
) (
  input wire clk, // system clock
  input wire nrst, // synchronous reset, active low
  input wire [31:0] bus_addr, // bus address
  input wire bus_a32, // 1 = long address mode, 0 = short
  input wire bus_strobe, // one-cycle access request
  input wire bus_write, // 1 = write, 0 = read
  input wire bus_d16, // 16-bit data access
  input wire [31:0] bus_wdata, // write data
  input wire iack_strobe, // one-cycle interrupt acknowledge request
  input wire [2:0] iack_level, // level being acknowledged
  input wire [15:0] upper_long_addr_switch, // address bits 31:16 in long mode
  input wire [7:0] upper_short_addr_switch, // address bits 23:16 in short mode
  input wire [3:0] low_addr_switch, // module rotary switch, address bits 15:12
  input wire addr11_jumper, // module jumper, address bit 11
  input wire [CHANNELS-1:0] count_in, // one-cycle count events per channel
  input wire ext_ctl_used, // external count enables in use
  input wire [CHANNELS-1:0] ext_enable, // external count enable per channel
  input wire ext_latch, // one-cycle external latch-shadow event
  output reg [31:0] bus_rdata_q, // read data or vector
  output reg bus_ack_q, // one-cycle answer
  output reg irq_req_q, // bus interrupt request, high active
  output reg [2:0] irq_level_q, // level of request
  output reg irq_pending_q // internal interrupt flag
);
  localparam K_NONE = 2'h0; // no pipeline access
  localparam K_REG = 2'h1; // module register access
  localparam K_BCAST = 2'h2; // broadcast key write
  localparam K_IACK = 2'h3; // acknowledge cycle

  // control state
  reg [CHANNELS-1:0] dis_mask_q; // count disable mask
  reg [11:0] id_irq_q; // writable low bits of id register
  reg bcast_en_q; // broadcast enable
  reg bcast_hs_q; // broadcast handshake controller
  reg [2:0] src_en_q; // irq source enables
  reg test_irq_q; // software test irq condition
  reg latch_flag_q; // latch input event seen
  reg run_q; // global count enable from keys
  reg [CW-1:0] cnt_q [0:CHANNELS-1]; // counters
  reg [CHANNELS-1:0] ovf_q; // overflow flags
  // access pipeline
  reg [1:0] p1_kind_q; // stage 1 access kind
  reg [1:0] p2_kind_q; // stage 2 access kind
  reg [11:0] p1_addr_q; // stage 1 offset
  reg [11:0] p2_addr_q; // stage 2 offset
  reg p1_d16_q; // stage 1 width
  reg p2_d16_q; // stage 2 width
  reg p1_wr_q; // stage 1 direction
  reg p2_wr_q; // stage 2 direction

  // decode helpers
  wire [31:0] sh_rd_data; // shadow word
  wire upper_ok; // class address match
  wire mod_sel; // this module addressed
  wire bc_sel; // broadcast class addressed
  wire [11:0] ofs; // local offset
  wire [4:0] win; // readout window
  wire acc; // register access this cycle
  wire wr_acc; // register write this cycle
  wire key_clear; // clear-all command
  wire key_shadow; // shadow transfer command
  wire key_on; // counting on command
  wire key_off; // counting off command
  wire copy_read; // copying readout
  wire clr_read; // clearing readout
  wire do_load; // load shadow now
  wire do_clear; // clear counters now
  wire [2:0] irq_cond; // per-source conditions
  wire pending; // any enabled condition
  reg [CW*CHANNELS-1:0] cnt_all; // packed counters
  wire [CHANNELS-1:0] cnt_ev; // qualified count events
  integer i;
  integer j; // counter loop index

  // select shadow half for 16-bit reads
  function [31:0] half_sel;
    input [31:0] w;
    input d16;
    input lowhalf;
    begin
      if (!d16) begin
        half_sel = w;
      end else if (lowhalf) begin
        half_sel = {16'h0000, w[15:0]};
      end else begin
        half_sel = {16'h0000, w[31:16]};
      end
    end
  endfunction

  // upper bits pick the class, switch plus jumper pick the module
  assign upper_ok = bus_a32 ? (bus_addr[31:16] == upper_long_addr_switch) :
                    (bus_addr[23:16] == upper_short_addr_switch);
  assign mod_sel = upper_ok && (bus_addr[15:11] == {low_addr_switch, addr11_jumper});
  assign bc_sel = upper_ok && (bus_addr[15:11] == 5'h00) && bcast_en_q;
  assign ofs = bus_addr[11:0];
  assign win = ofs[11:7];
  assign acc = bus_strobe && mod_sel;
  assign wr_acc = acc && bus_write;

  // key writes from own address or broadcast class
  wire key_wr = bus_strobe && bus_write && (mod_sel || bc_sel);
  assign key_clear = key_wr && (ofs == `OFS_KEY_CLEAR);
  assign key_shadow = key_wr && (ofs == `OFS_KEY_SHADOW);
  assign key_on = key_wr && (ofs == `OFS_KEY_CNT_ON);
  assign key_off = key_wr && (ofs == `OFS_KEY_CNT_OFF);

  // readout windows that copy counters first
  assign copy_read = acc && !bus_write &&
                     ((win == `WIN_READ_CNT) || (win == `WIN_READ_CLR));
  assign clr_read = acc && !bus_write && (win == `WIN_READ_CLR);
  assign do_load = key_shadow || copy_read || ext_latch;
  assign do_clear = key_clear || clr_read;

  // pack counters for the shadow load (values before any clear)
  always @* begin
    cnt_all = {CW*CHANNELS{1'b0}};
    for (i = 0; i < CHANNELS; i = i + 1) begin
      cnt_all[i*CW +: CW] = cnt_q[i];
    end
  end

  shadow_store #(
    .WIDTH(CW),
    .DEPTH(CHANNELS),
    .AW(5)
  ) u_shadow (
    .clk(clk),
    .load_all(do_load),
    .data_all(cnt_all),
    .rd_addr(p1_addr_q[6:2]),
    .rd_data_q(sh_rd_data)
  );

  // a channel counts only when running, unmasked and, while ext_ctl_used is set, externally enabled
  assign cnt_ev = count_in & {CHANNELS{run_q}} & ~dis_mask_q &
                  (ext_enable | {CHANNELS{!ext_ctl_used}});

  // counters and overflow flags; a wrap in the clear cycle keeps its flag
  always @(posedge clk) begin
    for (j = 0; j < CHANNELS; j = j + 1) begin
      if (!nrst) begin
        cnt_q[j] <= {CW{1'b0}};
        ovf_q[j] <= 1'b0;
      end else if (do_clear) begin
        cnt_q[j] <= {CW{1'b0}};
        ovf_q[j] <= cnt_ev[j] && (&cnt_q[j]);
      end else if (cnt_ev[j]) begin
        cnt_q[j] <= cnt_q[j] + {{(CW-1){1'b0}}, 1'b1};
        if (&cnt_q[j]) begin
          ovf_q[j] <= 1'b1;
        end
      end
    end
  end

  // software registers and j/k control bits
  always @(posedge clk) begin
    if (!nrst) begin
      dis_mask_q <= `RST_DISABLE_MASK;
      id_irq_q <= `RST_ID_IRQ;
      bcast_en_q <= 1'b0;
      bcast_hs_q <= 1'b0;
      src_en_q <= 3'h0;
      test_irq_q <= 1'b0;
      run_q <= 1'b1;
    end else begin
      if (wr_acc && (ofs == `OFS_CNT_DISABLE)) begin
        dis_mask_q <= bus_wdata[CHANNELS-1:0];
      end
      if (wr_acc && (ofs == `OFS_ID_IRQ)) begin
        id_irq_q <= bus_wdata[11:0];
      end
      if (wr_acc && (ofs == `OFS_CTRL)) begin
        // set bits first, paired clear bits win within one write
        if (bus_wdata[`CTL_SET_BCAST]) bcast_en_q <= 1'b1;
        if (bus_wdata[`CTL_CLR_BCAST]) bcast_en_q <= 1'b0;
        if (bus_wdata[`CTL_SET_BCAST_HS]) bcast_hs_q <= 1'b1;
        if (bus_wdata[`CTL_CLR_BCAST_HS]) bcast_hs_q <= 1'b0;
        if (bus_wdata[`CTL_SET_TEST_IRQ]) test_irq_q <= 1'b1;
        if (bus_wdata[`CTL_CLR_TEST_IRQ]) test_irq_q <= 1'b0;
        src_en_q <= (src_en_q | bus_wdata[`CTL_SET_IRQ_SRC +: 3]) &
                    ~bus_wdata[`CTL_CLR_IRQ_SRC +: 3];
      end
      if (key_on) begin
        run_q <= 1'b1;
      end else if (key_off) begin
        run_q <= 1'b0;
      end
    end
  end

  // latch-input condition: event set wins over disable clearing it
  always @(posedge clk) begin
    if (!nrst) begin
      latch_flag_q <= 1'b0;
    end else if (ext_latch) begin
      latch_flag_q <= 1'b1;
    end else if (!src_en_q[1]) begin
      latch_flag_q <= 1'b0;
    end
  end

  // interrupt conditions gated by source enables
  assign irq_cond = {test_irq_q, latch_flag_q, |ovf_q};
  assign pending = |(irq_cond & src_en_q);

  // internal flag and bus request outputs
  always @(posedge clk) begin
    if (!nrst) begin
      irq_pending_q <= 1'b0;
      irq_req_q <= 1'b0;
      irq_level_q <= 3'h0;
    end else begin
      irq_pending_q <= pending;
      irq_req_q <= pending && id_irq_q[`IDR_IRQ_ENABLE] &&
                   (id_irq_q[`IDR_LEVEL_LSB +: 3] != 3'h0);
      irq_level_q <= id_irq_q[`IDR_LEVEL_LSB +: 3];
    end
  end

  // two-stage access pipeline, answer two edges after the request edge
  always @(posedge clk) begin
    if (!nrst) begin
      p1_kind_q <= K_NONE;
      p2_kind_q <= K_NONE;
      p1_addr_q <= 12'h000;
      p2_addr_q <= 12'h000;
      p1_d16_q <= 1'b0;
      p2_d16_q <= 1'b0;
      p1_wr_q <= 1'b0;
      p2_wr_q <= 1'b0;
    end else begin
      if (iack_strobe && irq_req_q && (iack_level == irq_level_q)) begin
        p1_kind_q <= K_IACK;
      end else if (acc) begin
        p1_kind_q <= K_REG;
      end else if (key_wr && !mod_sel && bcast_hs_q) begin
        p1_kind_q <= K_BCAST;
      end else begin
        p1_kind_q <= K_NONE;
      end
      p1_addr_q <= ofs;
      p1_d16_q <= bus_d16;
      p1_wr_q <= bus_write;
      p2_kind_q <= p1_kind_q;
      p2_addr_q <= p1_addr_q;
      p2_d16_q <= p1_d16_q;
      p2_wr_q <= p1_wr_q;
    end
  end

  // answer stage: read data mux and acknowledge
  always @(posedge clk) begin
    if (!nrst) begin
      bus_rdata_q <= 32'h00000000;
      bus_ack_q <= 1'b0;
    end else begin
      bus_ack_q <= (p2_kind_q != K_NONE);
      bus_rdata_q <= 32'h00000000;
      if (p2_kind_q == K_IACK) begin
        bus_rdata_q <= {24'h000000, id_irq_q[7:0]};
      end else if ((p2_kind_q == K_REG) && !p2_wr_q) begin
        case (p2_addr_q[11:7])
          `WIN_SHADOW, `WIN_READ_CNT, `WIN_READ_CLR: begin
            bus_rdata_q <= half_sel(sh_rd_data, p2_d16_q, p2_addr_q[1]);
          end
          default: begin
            case (p2_addr_q)
              `OFS_CTRL: begin
                // conditions 26:24, enables 22:20, pending 16
                bus_rdata_q <= {5'h00, irq_cond, 1'b0, src_en_q,
                                3'h0, irq_pending_q, 8'h00, bcast_hs_q,
                                bcast_en_q, 4'h0, test_irq_q, 1'b0};
              end
              `OFS_ID_IRQ: begin
                bus_rdata_q <= {MODULE_ID, VERSION_ID, id_irq_q};
              end
              `OFS_OVF_1_8: begin
                bus_rdata_q <= {ovf_q[7:0], 24'h000000};
              end
              `OFS_OVF_9_16: begin
                bus_rdata_q <= {ovf_q[15:8], 24'h000000};
              end
              `OFS_OVF_17_24: begin
                bus_rdata_q <= {ovf_q[23:16], 24'h000000};
              end
              `OFS_OVF_25_32: begin
                bus_rdata_q <= {ovf_q[31:24], 24'h000000};
              end
              default: begin
                // disable mask and unmapped offsets read zero
                bus_rdata_q <= 32'h00000000;
              end
            endcase
          end
        endcase
      end
    end
  end
endmodule

/* File: testbench/scaler_readout_control_assertions.sv */
module readout_checker (
  input wire clk, // clock
  input wire nrst, // reset, low
  input wire [31:0] bus_addr, // address
  input wire bus_a32, // long mode
  input wire bus_strobe, // request
  input wire bus_write, // write
  input wire iack_strobe, // acknowledge
  input wire [2:0] iack_level, // ack level
  input wire [15:0] upper_long_addr_switch, // strap
  input wire [7:0] upper_short_addr_switch, // strap
  input wire [3:0] low_addr_switch, // strap
  input wire addr11_jumper, // strap
  input wire [31:0] bus_rdata_q, // read data
  input wire bus_ack_q, // answer
  input wire irq_req_q, // request
  input wire [2:0] irq_level_q, // level
  input wire irq_pending_q // pending
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // upper bits match in the active address mode
  wire up_ok = bus_a32 ? bus_addr[31:16] == upper_long_addr_switch
    : bus_addr[23:16] == upper_short_addr_switch;
  wire [4:0] me = {low_addr_switch, addr11_jumper}; // own module field
  wire own = bus_strobe && up_ok && bus_addr[15:11] == me; // own module hit
  wire alien = bus_strobe && !(up_ok && (bus_addr[15:11] == me || bus_addr[15:11] == 5'h00));
  wire quiet = !bus_strobe && !iack_strobe; // no request this cycle
  wire iack_hit = iack_strobe && irq_req_q && iack_level == irq_level_q; // matching ack
  // two request-free cycles so no other answer lands
  sequence calm2;
    quiet [*2];
  endsequence
  sequence iack_miss;
    iack_strobe && !bus_strobe && !iack_hit ##1 calm2;
  endsequence
  AST_OWN_ANSWER: assert property (own |-> ##3 bus_ack_q)
    else $error("own access not answered");
  AST_ALIEN_SILENT: assert property (alien ##1 calm2 |=> !bus_ack_q)
    else $error("foreign address answered");
  AST_MASK_READS_ZERO: assert property (own && !bus_write && bus_addr[11:0] == 12'h00C
    |-> ##3 bus_rdata_q == 32'h0) else $error("mask read not zero");
  AST_IDLE_DATA_ZERO: assert property (!bus_ack_q |-> bus_rdata_q == 32'h0)
    else $error("data outside answer");
  AST_ACK_HAS_CAUSE: assert property (bus_ack_q |-> $past(bus_strobe, 3) || $past(iack_strobe, 3))
    else $error("answer without request");
  AST_IACK_VECTOR: assert property (iack_hit |-> ##3 bus_ack_q && bus_rdata_q[31:8] == 24'h0)
    else $error("vector wider than a byte");
  AST_IACK_REFUSED: assert property (iack_miss |=> !bus_ack_q)
    else $error("acknowledge answered wrongly");
  AST_REQ_LEVEL: assert property (irq_req_q |-> irq_level_q != 3'h0 && irq_pending_q)
    else $error("request without level or pending");
endmodule
bind scaler_readout_control readout_checker i_readout_checker (.clk(clk), .nrst(nrst),
  .bus_addr(bus_addr), .bus_a32(bus_a32), .bus_strobe(bus_strobe), .bus_write(bus_write),
  .iack_strobe(iack_strobe), .iack_level(iack_level), .addr11_jumper(addr11_jumper),
  .upper_long_addr_switch(upper_long_addr_switch), .low_addr_switch(low_addr_switch),
  .upper_short_addr_switch(upper_short_addr_switch), .bus_rdata_q(bus_rdata_q),
  .bus_ack_q(bus_ack_q), .irq_req_q(irq_req_q), .irq_level_q(irq_level_q),
  .irq_pending_q(irq_pending_q));

/* File: testbench/vme_master_model.sv */
module vme_master_model (
  input wire clk, // clock
  input wire [31:0] bus_rdata_q, // data back
  input wire bus_ack_q, // answer
  output logic [31:0] bus_addr = 32'h0, // address
  output logic bus_a32 = 1'b1, // long mode
  output logic bus_strobe = 1'b0, // request
  output logic bus_write = 1'b0, // write
  output logic bus_d16 = 1'b0, // half word
  output logic [31:0] bus_wdata = 32'h0, // write data
  output logic iack_strobe = 1'b0, // acknowledge
  output logic [2:0] iack_level = 3'h0 // ack level
);
  timeunit 1ns;
  timeprecision 1ps;
  // one transfer: strobe one cycle, then wait a bounded time for the answer
  task automatic xfer(input bit iack, input bit wr, input bit d16, input bit a32,
    input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd, output bit ok);
    ok = 0;
    rd = 32'h0;
    @(negedge clk);
    bus_addr = a;
    bus_a32 = a32;
    bus_write = wr;
    bus_d16 = d16;
    bus_wdata = wd;
    iack_level = a[2:0];
    bus_strobe = !iack;
    iack_strobe = iack;
    @(negedge clk);
    // released lines show the inverse so stale values never look valid
    bus_strobe = 0;
    iack_strobe = 0;
    bus_addr = ~a;
    bus_wdata = ~wd;
    for (int n = 0; n < 5 && !ok; n++) begin
      @(posedge clk);
      if (bus_ack_q === 1'b1) begin
        ok = 1;
        rd = bus_rdata_q;
      end
    end
  endtask
endmodule

/* File: testbench/scaler_readout_control_test.sv */
module scaler_readout_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int p; bit w; logic [11:0] o; logic [31:0] d; logic [31:0] e;} row_t;
  localparam logic [31:0] BC = 32'h32000000; // broadcast class
  logic clk = 0, nrst = 0, ext_ctl_used = 0, ext_latch = 0; // stimulus
  logic [31:0] count_in = 32'h0, ext_enable = 32'hFFFFFFFF; // channel inputs
  wire [31:0] bus_addr, bus_wdata, bus_rdata_q; // bus
  wire bus_a32, bus_strobe, bus_write, bus_d16, iack_strobe, bus_ack_q; // bus
  wire [2:0] iack_level, irq_level_q; // levels
  wire irq_req_q, irq_pending_q; // interrupt outputs
  logic [31:0] rv; // last read data
  bit okv; // last answer seen
  int bad_count = 0, tests_run = 0, cyc = 0; // counters
  // plain offsets inside the own module window
  row_t rows [14] = '{'{0, 1, 12'h00C, 32'h5, 0}, '{0, 0, 12'h00C, 0, 0},
    '{0, 1, 12'h004, 32'hA5C, 0}, '{0, 0, 12'h004, 0, 32'h12341A5C}, '{0, 0, 12'h010, 0, 0},
    '{3, 0, 12'h280, 0, 0}, '{0, 0, 12'h284, 0, 3}, '{0, 0, 12'h288, 0, 0},
    '{0, 0, 12'h284, 0, 3}, '{0, 0, 12'h304, 0, 3}, '{1, 0, 12'h20C, 0, 3},
    '{0, 0, 12'h28C, 0, 1}, '{0, 1, 12'h000, 32'h40, 0}, '{0, 0, 12'h000, 0, 32'h40}};
  initial begin
    forever #4 clk = ~clk;
  end
  scaler_readout_control i_scaler_readout_control (.clk(clk), .nrst(nrst), .bus_addr(bus_addr),
    .bus_a32(bus_a32), .bus_strobe(bus_strobe), .bus_write(bus_write), .bus_d16(bus_d16),
    .bus_wdata(bus_wdata), .iack_strobe(iack_strobe), .iack_level(iack_level),
    .upper_long_addr_switch(16'h3200), .upper_short_addr_switch(8'h54),
    .low_addr_switch(4'h1), .addr11_jumper(1'b0), .count_in(count_in),
    .ext_ctl_used(ext_ctl_used), .ext_enable(ext_enable), .ext_latch(ext_latch),
    .bus_rdata_q(bus_rdata_q), .bus_ack_q(bus_ack_q), .irq_req_q(irq_req_q),
    .irq_level_q(irq_level_q), .irq_pending_q(irq_pending_q));
  vme_master_model i_vme_master_model (.clk(clk), .bus_rdata_q(bus_rdata_q),
    .bus_ack_q(bus_ack_q), .bus_addr(bus_addr), .bus_a32(bus_a32), .bus_strobe(bus_strobe),
    .bus_write(bus_write), .bus_d16(bus_d16), .bus_wdata(bus_wdata),
    .iack_strobe(iack_strobe), .iack_level(iack_level));
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // own-window long access
  task acc(input bit w, input logic [31:0] o, input logic [31:0] d);
    i_vme_master_model.xfer(1'b0, w, 1'b0, 1'b1, 32'h32001000 | o, d, rv, okv);
  endtask
  task bc(input logic [31:0] o);
    i_vme_master_model.xfer(1'b0, 1'b1, 1'b0, 1'b1, BC | o, 32'h0, rv, okv);
  endtask
  // count pulses into every channel
  task pulse(input int n);
    repeat (n) begin
      @(negedge clk);
      count_in = 32'hFFFFFFFF;
      @(negedge clk);
      count_in = 32'h0;
    end
  endtask
  task irqchk(input logic p, input logic q);
    @(negedge clk);
    check("pending", {31'h0, irq_pending_q}, {31'h0, p});
    check("request", {31'h0, irq_req_q}, {31'h0, q});
  endtask
  // cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    nrst = 1;
    foreach (rows[i]) begin
      pulse(rows[i].p);
      acc(rows[i].w, rows[i].o, rows[i].d);
      check("row ack", {31'h0, okv}, 32'h1);
      check("row data", rv, rows[i].e);
    end
    i_vme_master_model.xfer(1'b0, 1'b0, 1'b1, 1'b1, 32'h32001204, 32'h0, rv, okv);
    check("d16 high", rv, 32'h0);
    i_vme_master_model.xfer(1'b0, 1'b0, 1'b1, 1'b1, 32'h32001206, 32'h0, rv, okv);
    check("d16 low", rv, 32'h1);
    pulse(2);
    bc(32'h34);
    check("no handshake", {31'h0, okv}, 32'h0);
    acc(0, 32'h204, 0);
    check("bcast shadow", rv, 32'h3);
    acc(1, 32'h0, 32'h80);
    bc(32'h30);
    check("handshake", {31'h0, okv}, 32'h1);
    acc(0, 32'h284, 0);
    check("bcast clear", rv, 32'h0);
    acc(1, 32'h0, 32'h4000);
    pulse(1);
    bc(32'h34);
    check("bcast off", {31'h0, okv}, 32'h0);
    acc(0, 32'h204, 0);
    check("no bcast load", rv, 32'h0);
    acc(1, 32'h03C, 0);
    pulse(2);
    acc(0, 32'h284, 0);
    check("count off", rv, 32'h1);
    acc(1, 32'h038, 0);
    pulse(1);
    acc(0, 32'h284, 0);
    check("count on", rv, 32'h2);
    @(negedge clk);
    ext_ctl_used = 1;
    ext_enable = 32'h2;
    pulse(1);
    acc(0, 32'h284, 0);
    check("ext on", rv, 32'h3);
    acc(0, 32'h28C, 0);
    check("ext off", rv, 32'h2);
    @(negedge clk);
    ext_ctl_used = 0;
    acc(1, 32'h0, 32'h400002);
    irqchk(1, 1);
    check("level", {29'h0, irq_level_q}, 32'h2);
    acc(0, 32'h0, 0);
    check("ctrl status", rv, 32'h04410082);
    i_vme_master_model.xfer(1'b1, 1'b0, 1'b0, 1'b1, 32'h3, 32'h0, rv, okv);
    check("wrong level", {31'h0, okv}, 32'h0);
    i_vme_master_model.xfer(1'b1, 1'b0, 1'b0, 1'b1, 32'h2, 32'h0, rv, okv);
    check("vector", rv, 32'h5C);
    acc(1, 32'h0, 32'h40000000);
    irqchk(0, 0);
    acc(1, 32'h0, 32'h200);
    acc(1, 32'h0, 32'h400000);
    irqchk(0, 0);
    acc(1, 32'h4, 32'h25C);
    acc(1, 32'h0, 32'h2);
    irqchk(1, 0);
    acc(1, 32'h0, 32'h40000200);
    acc(1, 32'h0, 32'h200000);
    pulse(1);
    @(negedge clk);
    ext_latch = 1;
    @(negedge clk);
    ext_latch = 0;
    irqchk(1, 0);
    acc(0, 32'h204, 0);
    check("latch shadow", rv, 32'h4);
    i_vme_master_model.xfer(1'b0, 1'b0, 1'b0, 1'b0, 32'h00541004, 32'h0, rv, okv);
    check("short mode", rv, 32'h1234125C);
    acc(0, 32'h0804, 0);
    check("other module", {31'h0, okv}, 32'h0);
    // second reset in mid-run
    @(negedge clk);
    nrst = 0;
    repeat (2) @(negedge clk);
    check("reset data", bus_rdata_q, 32'h0);
    check("reset outs", {26'h0, bus_ack_q, irq_pending_q, irq_req_q, irq_level_q}, 32'h0);
    nrst = 1;
    pulse(1);
    acc(0, 32'h280, 0);
    check("mask reset", rv, 32'h1);
    acc(0, 32'h380, 0);
    check("overflow", {24'h0, rv[31:24]}, 32'h0);
    tally_and_finish;
  end
endmodule
